// >>> include/pss_pkg.sv
package pss_pkg;

   // ************************************************************
   // Register map
   // ************************************************************
   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_SOURCE    = 4'h1;
   localparam logic [3:0] REG_COUNT     = 4'h2;
   localparam logic [3:0] REG_POINTER   = 4'h3;
   localparam logic [3:0] REG_COMMAND   = 4'h4;
   localparam logic [3:0] REG_ACT_DATA  = 4'h5;
   localparam logic [3:0] REG_CUR_SET   = 4'h6;
   localparam logic [3:0] REG_STATUS    = 4'h7;

   // ************************************************************
   // Field positions
   // ************************************************************
   localparam int CTRL_ON_BIT      = 0;
   localparam int CTRL_INV1_BIT    = 1;
   localparam int CTRL_INV2_BIT    = 2;
   localparam int SRC_ADV_LSB      = 0;
   localparam int SRC_RST_LSB      = 4;
   localparam int CMD_STEP_BIT     = 0;
   localparam int CMD_REWIND_BIT   = 1;
   localparam int CMD_SAVE_BIT     = 2;
   localparam int CMD_COPY_BIT     = 3;

   // ************************************************************
   // Sizes and reset values
   // ************************************************************
   localparam int SET_NUM          = 64;
   localparam int IDX_W            = 6;
   localparam int PAR_W            = 32;
   localparam logic [IDX_W-1:0] IDX_ZERO  = 6'h00;
   localparam logic [IDX_W-1:0] IDX_ONE   = 6'h01;
   localparam logic [IDX_W-1:0] IDX_MAX   = 6'h3F;
   localparam logic [IDX_W:0]   COUNT_RST = 7'h02;
   localparam logic [PAR_W-1:0] PAR_RST   = 32'h0000_0000;

   // ************************************************************
   // Control action origins
   // ************************************************************
   typedef enum logic [1:0] {
      SRC_DISABLED = 2'h0,
      SRC_ALWAYS   = 2'h1,
      SRC_LINE1    = 2'h2,
      SRC_LINE2    = 2'h3
   } pss_origin_t;

   typedef enum logic [2:0] {
      ST_OFF  = 3'b001,
      ST_LOAD = 3'b010,
      ST_RUN  = 3'b100
   } pss_state_t;

endpackage

// >>> src/pss_set_store.sv
`timescale 1ns/100ps
module pss_set_store
   import pss_pkg::*;
(
   // Clock
   input  wire logic             clk,
   // Write port
   input  wire logic             wr_en,
   input  wire logic [IDX_W-1:0] wr_idx,
   input  wire logic [PAR_W-1:0] wr_data,
   // Read port
   input  wire logic [IDX_W-1:0] rd_idx,
   output logic      [PAR_W-1:0] rd_data
);

   // ************************************************************
   // Set memory
   // ************************************************************
   logic [PAR_W-1:0] mem [SET_NUM];

   always_ff @(posedge clk) begin
      if (wr_en) begin
         mem[wr_idx] <= wr_data;
      end
   end

   assign rd_data = mem[rd_idx];

endmodule // pss_set_store

// >>> src/pss_sequencer.sv
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// - Switching on loads set 0 into active
// - Always-active source advances on every trigger
// - Line status 1 advances, 0 holds
// - Status is pin level, optionally inverted
// - Line 1 or line 2, same behaviour
// - Sync advance past last set wraps to 0
// - Restart line status 1 loads set 0
// - Restart line status 0 does nothing
// - Restart beats advance on same trigger
// - Each untimed step in run adds one to current set, unless a rewind or a sync restart or advance wins that cycle
// - Untimed step from last set wraps to 0
// - Untimed rewind loads set 0 at once
// - Steps after rewind pick the trigger set
// - Sync advance after rewind selects set 1
// - Save copies active out, copy loads set
// - Index spans 0 to 63, contiguous from 0
// - Disabled source still takes untimed commands
module pss_sequencer
   import pss_pkg::*;
(
   // Clock and reset
   input  wire logic             CLK_SYS,
   input  wire logic             RESET,
   // Register port
   input  wire logic [3:0]       ADDR,
   input  wire logic [31:0]      WDATA,
   input  wire logic             WR,
   input  wire logic             RD,
   output logic      [31:0]      RDATA,
   // Acquisition side
   input  wire logic             FRAME_TRIG,
   input  wire logic             LINE1,
   input  wire logic             LINE2,
   output logic                  TRIG_WAIT,
   output logic      [PAR_W-1:0] ACTIVE_SET,
   output logic      [IDX_W-1:0] CUR_SET,
   output logic                  ACQ_PULSE
);

   // ************************************************************
   // Configuration registers
   // ************************************************************
   logic             sequencer_on;
   logic             inv1;
   logic             inv2;
   pss_origin_t      adv_origin;
   pss_origin_t      rst_origin;
   logic [IDX_W:0]   configured_set_count;
   logic [IDX_W-1:0] set_pointer;
   logic [PAR_W-1:0] act_data;
   logic [IDX_W-1:0] cur_idx;
   pss_state_t       state;

   logic             wr_ctrl;
   logic             wr_cmd;
   logic             untimed_step;
   logic             untimed_rewind;
   logic             save_active_to_set;
   logic             copy_set_to_active;
   logic             line1_status;
   logic             line2_status;
   logic             adv_req;
   logic             rst_req;
   logic             sync_go;
   logic [IDX_W-1:0] last_idx;
   logic [IDX_W-1:0] next_idx;
   logic [IDX_W-1:0] rd_idx;
   logic [PAR_W-1:0] mem_data;

   assign wr_ctrl = WR && (ADDR == REG_CTRL);
   assign wr_cmd  = WR && (ADDR == REG_COMMAND);
   assign untimed_step       = wr_cmd && WDATA[CMD_STEP_BIT];
   assign untimed_rewind     = wr_cmd && WDATA[CMD_REWIND_BIT];
   assign save_active_to_set = wr_cmd && WDATA[CMD_SAVE_BIT];
   assign copy_set_to_active = wr_cmd && WDATA[CMD_COPY_BIT];

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         sequencer_on <= 1'b0;
         inv1         <= 1'b0;
         inv2         <= 1'b0;
      end else if (wr_ctrl) begin
         sequencer_on <= WDATA[CTRL_ON_BIT];
         inv1         <= WDATA[CTRL_INV1_BIT];
         inv2         <= WDATA[CTRL_INV2_BIT];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         adv_origin <= SRC_DISABLED;
         rst_origin <= SRC_DISABLED;
      end else if (WR && (ADDR == REG_SOURCE)) begin
         adv_origin <= pss_origin_t'(WDATA[SRC_ADV_LSB +: 2]);
         rst_origin <= pss_origin_t'(WDATA[SRC_RST_LSB +: 2]);
      end
   end

   // Count clipped to 1..64
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         configured_set_count <= COUNT_RST;
      end else if (WR && (ADDR == REG_COUNT)) begin
         if (WDATA[6:0] == 7'h00) begin
            configured_set_count <= 7'h01;
         end else if (WDATA[6:0] > 7'h40) begin
            configured_set_count <= 7'h40;
         end else begin
            configured_set_count <= WDATA[6:0];
         end
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         set_pointer <= IDX_ZERO;
      end else if (WR && (ADDR == REG_POINTER)) begin
         set_pointer <= WDATA[IDX_W-1:0];
      end
   end

   // ************************************************************
   // Line status and sync requests
   // ************************************************************
   assign line1_status = LINE1 ^ inv1;
   assign line2_status = LINE2 ^ inv2;

   function automatic logic origin_hit(pss_origin_t o, logic s1, logic s2);
      case (o)
         SRC_ALWAYS: origin_hit = 1'b1;
         SRC_LINE1:  origin_hit = s1;
         SRC_LINE2:  origin_hit = s2;
         default:    origin_hit = 1'b0;
      endcase
   endfunction

   assign adv_req = origin_hit(adv_origin, line1_status, line2_status);
   assign rst_req = (rst_origin != SRC_ALWAYS) &&
                    origin_hit(rst_origin, line1_status, line2_status);
   assign last_idx = configured_set_count[IDX_W-1:0] - IDX_ONE;
   assign sync_go  = (state == ST_RUN) && FRAME_TRIG;

   // Wrapping increment
   assign next_idx = (cur_idx >= last_idx) ? IDX_ZERO
                                           : cur_idx + IDX_ONE;

   // ************************************************************
   // Sequencer state and current index
   // ************************************************************
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         state   <= ST_OFF;
         cur_idx <= IDX_ZERO;
      end else begin
         case (state)
            ST_OFF: begin
               if (sequencer_on) begin
                  state   <= ST_LOAD;
                  cur_idx <= IDX_ZERO;
               end
            end
            ST_LOAD: begin
               state <= sequencer_on ? ST_RUN : ST_OFF;
            end
            ST_RUN: begin
               if (!sequencer_on) begin
                  state <= ST_OFF;
               end else if (untimed_rewind) begin
                  cur_idx <= IDX_ZERO;
                  state   <= ST_LOAD;
               end else if (sync_go && rst_req) begin
                  cur_idx <= IDX_ZERO;
                  state   <= ST_LOAD;
               end else if (sync_go && adv_req) begin
                  cur_idx <= next_idx;
                  state   <= ST_LOAD;
               end else if (untimed_step) begin
                  cur_idx <= next_idx;
                  state   <= ST_LOAD;
               end
            end
            default: state <= ST_OFF;
         endcase
      end
   end

   // ************************************************************
   // Set memory and active set
   // ************************************************************
   assign rd_idx = (state == ST_LOAD) ? cur_idx : set_pointer;

   pss_set_store u_store (
      .clk     (CLK_SYS),
      .wr_en   (save_active_to_set),
      .wr_idx  (set_pointer),
      .wr_data (act_data),
      .rd_idx  (rd_idx),
      .rd_data (mem_data)
   );

   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         act_data <= PAR_RST;
      end else if (state == ST_LOAD) begin
         act_data <= mem_data;
      end else if (copy_set_to_active) begin
         act_data <= mem_data;
      end else if (WR && (ADDR == REG_ACT_DATA)) begin
         act_data <= WDATA;
      end
   end

   // ************************************************************
   // Acquisition outputs
   // ************************************************************
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         ACQ_PULSE <= 1'b0;
         TRIG_WAIT <= 1'b0;
      end else begin
         ACQ_PULSE <= sync_go;
         TRIG_WAIT <= (state == ST_RUN) && !FRAME_TRIG;
      end
   end

   assign ACTIVE_SET = act_data;
   assign CUR_SET    = cur_idx;

   // ************************************************************
   // Register read back
   // ************************************************************
   always_ff @(posedge CLK_SYS) begin
      if (RESET) begin
         RDATA <= 32'h0000_0000;
      end else if (!RD) begin
         RDATA <= 32'h0000_0000;
      end else if (ADDR == REG_CTRL) begin
         RDATA <= {29'h0000_0000, inv2, inv1, sequencer_on};
      end else if (ADDR == REG_SOURCE) begin
         RDATA <= {26'h000_0000, rst_origin, 2'h0, adv_origin};
      end else if (ADDR == REG_COUNT) begin
         RDATA <= {25'h000_0000, configured_set_count};
      end else if (ADDR == REG_POINTER) begin
         RDATA <= {26'h000_0000, set_pointer};
      end else if (ADDR == REG_ACT_DATA) begin
         RDATA <= act_data;
      end else if (ADDR == REG_CUR_SET) begin
         RDATA <= {26'h000_0000, cur_idx};
      end else if (ADDR == REG_STATUS) begin
         RDATA <= {29'h0000_0000, state};
      end else begin
         RDATA <= 32'h0000_0000;
      end
   end

   // ************************************************************
   // Checks
   // ************************************************************
   property p_on_load;
      @(posedge CLK_SYS) disable iff (RESET)
      (state == ST_OFF && sequencer_on) |=> (cur_idx == IDX_ZERO)
         ##1 (act_data == $past(mem_data));
   endproperty
   a_on_load: assert property (p_on_load)
      else $error("enable did not load set 0");

   property p_always_adv;
      @(posedge CLK_SYS) disable iff (RESET)
      (sync_go && adv_origin == SRC_ALWAYS && !rst_req && !untimed_rewind
       && sequencer_on) |=> (cur_idx == $past(next_idx));
   endproperty
   a_always_adv: assert property (p_always_adv)
      else $error("always source did not advance");

   property p_line_hold;
      @(posedge CLK_SYS) disable iff (RESET)
      (sync_go && adv_origin == SRC_LINE1 && !line1_status && !rst_req
       && !untimed_rewind && !untimed_step) |=> $stable(cur_idx);
   endproperty
   a_line_hold: assert property (p_line_hold)
      else $error("line status 0 changed set");

   property p_wrap;
      @(posedge CLK_SYS) disable iff (RESET)
      (state == ST_RUN && sequencer_on && cur_idx == last_idx
       && !untimed_rewind && ((sync_go && adv_req) || untimed_step))
      |=> (cur_idx == IDX_ZERO);
   endproperty
   a_wrap: assert property (p_wrap)
      else $error("last set did not wrap to 0");

   property p_restart_wins;
      @(posedge CLK_SYS) disable iff (RESET)
      (sync_go && sequencer_on && rst_req) |=> (cur_idx == IDX_ZERO)
         ##1 (act_data == $past(mem_data));
   endproperty
   a_restart_wins: assert property (p_restart_wins)
      else $error("restart did not win");

   property p_rewind;
      @(posedge CLK_SYS) disable iff (RESET)
      (state == ST_RUN && sequencer_on && untimed_rewind)
      |=> (cur_idx == IDX_ZERO) && (state == ST_LOAD);
   endproperty
   a_rewind: assert property (p_rewind)
      else $error("rewind did not load set 0");

   property p_step;
      @(posedge CLK_SYS) disable iff (RESET)
      (state == ST_RUN && sequencer_on && untimed_step && !untimed_rewind
       && !sync_go && cur_idx < last_idx) |=> (cur_idx == $past(cur_idx) + 1);
   endproperty
   a_step: assert property (p_step)
      else $error("step did not add one");

   property p_off_still;
      @(posedge CLK_SYS) disable iff (RESET)
      (state == ST_OFF && !sequencer_on) |=> $stable(cur_idx)
         && (state == ST_OFF);
   endproperty
   a_off_still: assert property (p_off_still)
      else $error("disabled sequencer moved");

   property p_range;
      @(posedge CLK_SYS) disable iff (RESET)
      (configured_set_count != 7'h00) && (configured_set_count <= 7'h40)
      && (cur_idx <= last_idx || $changed(configured_set_count)
          || $past(WR));
   endproperty
   a_range: assert property (p_range)
      else $error("set count or index out of range");

   property p_quiet_trig;
      @(posedge CLK_SYS) disable iff (RESET)
      (sync_go && sequencer_on && !rst_req && !adv_req && !untimed_rewind
       && !untimed_step) |=> $stable(cur_idx) && (state == ST_RUN);
   endproperty
   a_quiet_trig: assert property (p_quiet_trig)
      else $error("trigger without request moved set");

   property p_sync_acq;
      @(posedge CLK_SYS) disable iff (RESET)
      (sync_go && sequencer_on) |=> ACQ_PULSE
         && ((state == ST_LOAD) || $stable(cur_idx));
   endproperty
   a_sync_acq: assert property (p_sync_acq)
      else $error("accepted trigger gave no acquisition");

endmodule // pss_sequencer

// >>> verification/pss_line_model.sv
`timescale 1ns/100ps
module pss_line_model (
   // Clock
   input  wire logic clk,
   // Requests from the bench
   input  wire logic fire,
   input  wire logic want1,
   input  wire logic want2,
   // Pins toward the sequencer
   output logic      frame_trig,
   output logic      line1,
   output logic      line2
);
   logic armed;

   // ************************************************************
   // Lines settle one cycle ahead of the trigger pulse
   // ************************************************************
   initial begin
      armed      = 1'b0;
      frame_trig = 1'b0;
      line1      = 1'b0;
      line2      = 1'b0;
   end

   always @(posedge clk) begin
      if (fire) begin
         line1 <= want1;
         line2 <= want2;
      end
      armed      <= fire;
      frame_trig <= armed;
   end
endmodule // pss_line_model

// >>> verification/test_pss_sequencer.sv
`timescale 1ns/100ps
module test_pss_sequencer;
   import pss_pkg::*;
   logic             clk;
   logic             rst;
   logic [3:0]       addr;
   logic [31:0]      wdata;
   logic             wr_s;
   logic             rd_s;
   logic [31:0]      rdata;
   logic             trig;
   logic             ln1;
   logic             ln2;
   logic             twait;
   logic [PAR_W-1:0] active;
   logic [IDX_W-1:0] cur;
   logic             acq;
   logic             fire;
   logic             w1;
   logic             w2;
   logic [31:0]      r;
   logic             tw_set;
   logic             tw_trig;
   int               n_mismatch;
   int               n_checks;
   int               n_acq;
   int               a0;

   pss_sequencer DUT (.CLK_SYS(clk), .RESET(rst), .ADDR(addr),
      .WDATA(wdata), .WR(wr_s), .RD(rd_s), .RDATA(rdata),
      .FRAME_TRIG(trig), .LINE1(ln1), .LINE2(ln2), .TRIG_WAIT(twait),
      .ACTIVE_SET(active), .CUR_SET(cur), .ACQ_PULSE(acq));
   pss_line_model u_lines (.clk(clk), .fire(fire), .want1(w1),
      .want2(w2), .frame_trig(trig), .line1(ln1), .line2(ln2));

   // ************************************************************
   // Bus and trigger tasks
   // ************************************************************
   function automatic logic [31:0] val(input logic [31:0] i);
      return 32'hC0DE_0000 | i;
   endfunction
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [3:0] a, input logic [31:0] d);
      addr <= a; wdata <= d; wr_s <= 1'b1;
      @(posedge clk) wr_s <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   task rd(input logic [3:0] a);
      addr <= a; rd_s <= 1'b1;
      @(posedge clk) rd_s <= 1'b0;
      #1 r = rdata;
      @(posedge clk);
   endtask
   task pulse(input logic a, input logic b);
      fire <= 1'b1; w1 <= a; w2 <= b;
      @(posedge clk) fire <= 1'b0;
      @(posedge clk) tw_set = twait;
      repeat (2) @(posedge clk);
      tw_trig = twait;
      repeat (2) @(posedge clk);
   endtask
   task see(input logic [31:0] c, input logic [31:0] p);
      chk({26'h0, cur}, c);
      chk(active, p);
   endtask
   task conclude;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ************************************************************
   // Scenarios
   // ************************************************************
   task t_reset;
      rd(REG_COUNT);  chk(r, {25'h0, COUNT_RST});
      rd(REG_STATUS); chk(r, 32'h0000_0001);
      rd(4'h8);       chk(r, 32'h0000_0000);
      for (int i = 0; i < 4; i++) begin
         wr(REG_ACT_DATA, val(i));
         wr(REG_POINTER, i);
         wr(REG_COMMAND, 32'h0000_0004);
      end
      wr(REG_COUNT, 32'h0000_0004);
      rd(REG_COUNT);  chk(r, 32'h0000_0004);
      $display("reset and fill done");
   endtask
   task t_always;
      wr(REG_SOURCE, 32'h0000_0001);
      wr(REG_CTRL, 32'h0000_0001);
      see(0, val(0));
      rd(REG_STATUS); chk(r, 32'h0000_0004);
      a0 = n_acq;
      for (int k = 1; k <= 4; k++) begin
         chk({31'h0, twait}, 32'h0000_0001);
         pulse(1'b0, 1'b0);
         chk({31'h0, tw_set}, 32'h0000_0001);
         chk({31'h0, tw_trig}, 32'h0000_0000);
         see(k % 4, val(k % 4));
      end
      chk(n_acq - a0, 4);
      $display("always advance done");
   endtask
   task t_lines;
      wr(REG_SOURCE, 32'h0000_0002);
      pulse(1'b0, 1'b1); see(0, val(0));
      pulse(1'b1, 1'b0); see(1, val(1));
      wr(REG_CTRL, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0003);
      pulse(1'b0, 1'b0); see(1, val(1));
      pulse(1'b1, 1'b1); see(1, val(1));
      wr(REG_SOURCE, 32'h0000_0003);
      wr(REG_CTRL, 32'h0000_0000);
      wr(REG_CTRL, 32'h0000_0001);
      pulse(1'b0, 1'b1); see(1, val(1));
      pulse(1'b1, 1'b0); see(1, val(1));
      wr(REG_CTRL, 32'h0000_0005);
      pulse(1'b1, 1'b1); see(1, val(1));
      wr(REG_CTRL, 32'h0000_0001);
      $display("line advance done");
   endtask
   task t_restart;
      wr(REG_SOURCE, 32'h0000_0032);
      pulse(1'b1, 1'b0); see(2, val(2));
      pulse(1'b1, 1'b1); see(0, val(0));
      pulse(1'b1, 1'b0); see(1, val(1));
      $display("sync restart done");
   endtask
   task t_untimed;
      wr(REG_SOURCE, 32'h0000_0000);
      pulse(1'b1, 1'b1); see(1, val(1));
      wr(REG_COMMAND, 32'h0000_0002);
      see(0, val(0));
      repeat (3) wr(REG_COMMAND, 32'h0000_0001);
      chk({26'h0, cur}, 3);
      pulse(1'b1, 1'b1); see(3, val(3));
      wr(REG_COMMAND, 32'h0000_0001);
      chk({26'h0, cur}, 0);
      wr(REG_SOURCE, 32'h0000_0001);
      wr(REG_COMMAND, 32'h0000_0001);
      wr(REG_COMMAND, 32'h0000_0002);
      see(0, val(0));
      pulse(1'b0, 1'b0); see(1, val(1));
      $display("untimed commands done");
   endtask
   task t_copy;
      wr(REG_POINTER, 32'h0000_0002);
      wr(REG_COMMAND, 32'h0000_0008);
      chk(active, val(2));
      wr(REG_ACT_DATA, 32'h5A5A_0F0F);
      wr(REG_POINTER, 32'h0000_0003);
      wr(REG_COMMAND, 32'h0000_0004);
      wr(REG_POINTER, 32'h0000_0000);
      wr(REG_COMMAND, 32'h0000_0008);
      chk(active, val(0));
      wr(REG_POINTER, 32'h0000_0003);
      wr(REG_COMMAND, 32'h0000_0008);
      chk(active, 32'h5A5A_0F0F);
      $display("save and copy done");
   endtask
   task t_off;
      wr(REG_CTRL, 32'h0000_0000);
      rd(REG_STATUS); chk(r, 32'h0000_0001);
      pulse(1'b1, 1'b1);
      wr(REG_COMMAND, 32'h0000_0001);
      wr(REG_COMMAND, 32'h0000_0002);
      see(1, 32'h5A5A_0F0F);
      $display("disabled done");
   endtask

   // ************************************************************
   // Clock, reset, watchdog and sequence
   // ************************************************************
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) if (acq === 1'b1) n_acq++;
   initial begin
      #(50 * 5000);
      n_mismatch++;
      conclude();
   end
   initial begin
      n_mismatch = 0; n_checks = 0; n_acq = 0;
      rst = 1'b1; addr = 4'h0; wdata = 32'h0000_0000;
      wr_s = 1'b0; rd_s = 1'b0; fire = 1'b0; w1 = 1'b0; w2 = 1'b0;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      t_reset();
      t_always();
      t_lines();
      t_restart();
      t_untimed();
      t_copy();
      t_off();
      conclude();
   end
endmodule // test_pss_sequencer
